// ==== adcseq_top.sv ====
// Successive-approximation converter sequencer with APB registers
// What this block does
// - Completion loads result, clears go, sets flag
// - Two periods, hold disconnected, before acquisition
// - Conversion takes at least twelve periods
// - Clock select picks 2, 8, 32 or RC
// - Port reads zero on analog pins
// - Conversion ignores channel and direction settings
// - Clearing go aborts, result pair unchanged
// - After abort wait two periods, reacquire
// - First segment between Tcy and one period
// - Justify select places result, zero fill
// - Result bytes are plain storage when off
// - RC clock delays start one instruction cycle
// - Sleep conversion only with RC clock
// - Enabled completion in sleep wakes device
// - Hold capacitor never discharged between conversions
// - Control layout fixed, bit one reads zero
// - Sleep with non-RC clock aborts, powers down
// - Reset turns converter off, aborts conversion
`timescale 1ns/1ps
module adcseq_top #(
  parameter int RC_CYCLES = adcseq_pkg::RC_TAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_pins,
  input wire logic comparator_in,
  input wire logic sleep_mode,
  output logic [9:0] dac_code,
  output logic [2:0] channel_sel,
  output logic hold_connect,
  output logic module_active,
  output logic conv_done_irq,
  output logic wake_req
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    adcseq_pkg::adcseq_state_t st; // Sequencer state
    logic [7:0] ctrl; // converter_control_reg
    logic [7:0] cfg; // converter_port_config
    logic [7:0] amask; // One marks an analog pin
    logic [7:0] res_hi; // result_high_byte
    logic [7:0] res_lo; // result_low_byte
    logic irqf; // conversion_done_irq_flag
    logic irqe; // conversion_irq_enable
    logic global_irq_enable; // global_irq_enable
    logic [9:0] sar; // Trial code
    logic [3:0] cnt; // Periods counted in state
    logic [2:0] instruction_cycle_time; // Cycles counted in state
    logic restart; // Realign the period divider
    logic pready; // APB answer
    logic pslverr; // Unmapped access
    logic [7:0] prdata; // Read data, low byte
    logic hold; // Hold capacitor connected
    logic active; // Module powered
    logic irq; // Interrupt request
    logic wake; // Wake from sleep
    logic [7:0] pin_s1; // Pin synchroniser, first stage
    logic [7:0] pin_s2; // Pin synchroniser, second stage
    logic cmp_s1; // Comparator synchroniser, first stage
    logic cmp_s2; // Comparator synchroniser, second stage
  } adcseq_state_all_t;
  adcseq_state_all_t s_reg;
  adcseq_state_all_t s_next;
  logic tad_tick; // Raw period tick
  logic tk; // Tick valid in current state
  logic [7:0] idx; // Register index
  logic acc; // Access phase
  logic wr_en; // Write takes effect this edge
  logic [7:0] wd; // Write data byte
  logic busy; // Conversion under way
  logic is_rc; // RC clock selected
  logic done_evt; // Conversion completes this edge
  logic abort_evt; // Conversion aborted this edge
  logic [9:0] final_code; // Code after last decision
  logic [15:0] pair; // Justified result
  logic mapped; // Index decodes
  logic [7:0] rd; // Read mux
  // ----------------------------------------------------------------
  // Period divider
  // ----------------------------------------------------------------
  adcseq_tad_gen #(
    .RC_CYCLES(RC_CYCLES)
  ) u_tad (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(s_reg.restart),
    .sel(adcseq_pkg::adcseq_clksel_t'(s_reg.ctrl[7:6])),
    .tick(tad_tick)
  );
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // A tick left over from before a restart is not trusted
  assign tk = tad_tick & ~s_reg.restart;
  assign idx = paddr[9:2];
  assign acc = psel & penable;
  assign wr_en = acc & pwrite & s_reg.pready;
  assign wd = pwdata[7:0];
  assign busy = (s_reg.st == adcseq_pkg::ADCSEQ_DELAY)
    | (s_reg.st == adcseq_pkg::ADCSEQ_FIRST)
    | (s_reg.st == adcseq_pkg::ADCSEQ_CONV);
  assign is_rc = s_reg.ctrl[7:6] == adcseq_pkg::ADCSEQ_CLK_RC;
  assign done_evt = (s_reg.st == adcseq_pkg::ADCSEQ_CONV) & tk
    & (s_reg.cnt == adcseq_pkg::LAST_CONV_TICK);
  // Last decision folds into the stored code
  assign final_code = s_reg.cmp_s2 ? s_reg.sar
    : (s_reg.sar & ~10'h001);
  // Right justified when the select is set
  assign pair = s_reg.cfg[adcseq_pkg::CFG_JUSTIFY_BIT]
    ? {6'h00, final_code} : {final_code, 6'h00};
  // Read multiplexer
  always_comb
  begin
    mapped = 1'b1;
    unique case (idx)
      adcseq_pkg::IDX_PORT: rd = s_reg.pin_s2 & ~s_reg.amask;
      adcseq_pkg::IDX_RESULT_HIGH: rd = s_reg.res_hi;
      adcseq_pkg::IDX_CONTROL: rd = s_reg.ctrl;
      adcseq_pkg::IDX_RESULT_LOW: rd = s_reg.res_lo;
      adcseq_pkg::IDX_PORT_CONFIG: rd = s_reg.cfg;
      adcseq_pkg::IDX_IRQ: rd = {5'h00, s_reg.global_irq_enable, s_reg.irqe, s_reg.irqf};
      adcseq_pkg::IDX_ANALOG_MASK: rd = s_reg.amask;
      default:
      begin
        // Unmapped reads zero and flags an error
        rd = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    abort_evt = 1'b0;
    s_next.restart = 1'b0;
    s_next.pin_s1 = port_pins;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.cmp_s1 = comparator_in;
    s_next.cmp_s2 = s_reg.cmp_s1;
    if (s_reg.instruction_cycle_time != 3'(adcseq_pkg::TCY_CYCLES - 1))
      s_next.instruction_cycle_time = s_reg.instruction_cycle_time + 3'h1;
    // APB: one wait state, then the transfer completes
    s_next.pready = acc & ~s_reg.pready;
    if (acc & ~s_reg.pready)
    begin
      s_next.prdata = pwrite ? 8'h00 : rd;
      s_next.pslverr = ~mapped;
    end
    else
    begin
      s_next.pslverr = 1'b0;
    end
    // Register writes
    if (wr_en)
    begin
      unique case (idx)
        adcseq_pkg::IDX_CONTROL:
        begin
          // Bit one stays zero
          s_next.ctrl = wd & adcseq_pkg::CTL_WMASK;
          // Go only latches while already powered
          if (!s_reg.ctrl[adcseq_pkg::CTL_ON_BIT])
            s_next.ctrl[adcseq_pkg::CTL_GO_BIT] = 1'b0;
        end
        adcseq_pkg::IDX_PORT_CONFIG: s_next.cfg = wd & adcseq_pkg::CFG_WMASK;
        // Result bytes always writable, completion overrides
        adcseq_pkg::IDX_RESULT_HIGH: s_next.res_hi = wd;
        adcseq_pkg::IDX_RESULT_LOW: s_next.res_lo = wd;
        adcseq_pkg::IDX_IRQ:
        begin
          s_next.irqf = wd[adcseq_pkg::IRQ_FLAG_BIT];
          s_next.irqe = wd[adcseq_pkg::IRQ_EN_BIT];
          s_next.global_irq_enable = wd[adcseq_pkg::IRQ_GIE_BIT];
        end
        adcseq_pkg::IDX_ANALOG_MASK: s_next.amask = wd;
        default:
        begin
          // Unmapped write is dropped
        end
      endcase
    end
    // Sequencer
    unique case (s_reg.st)
      adcseq_pkg::ADCSEQ_IDLE:
      begin
        // Acquiring on the selected channel
        if (s_next.ctrl[adcseq_pkg::CTL_GO_BIT]
            & s_reg.ctrl[adcseq_pkg::CTL_ON_BIT])
        begin
          s_next.instruction_cycle_time = 3'h0;
          s_next.restart = 1'b1;
          if (s_next.ctrl[7:6] == adcseq_pkg::ADCSEQ_CLK_RC)
            s_next.st = adcseq_pkg::ADCSEQ_DELAY;
          else
            s_next.st = adcseq_pkg::ADCSEQ_FIRST;
        end
      end
      adcseq_pkg::ADCSEQ_DELAY:
      begin
        // One instruction cycle lets a sleep take hold first
        if (s_reg.instruction_cycle_time == 3'(adcseq_pkg::TCY_CYCLES - 1))
        begin
          s_next.st = adcseq_pkg::ADCSEQ_FIRST;
          s_next.instruction_cycle_time = 3'h0;
          s_next.restart = 1'b1;
        end
      end
      adcseq_pkg::ADCSEQ_FIRST:
      begin
        // Ends at the first period end, no earlier than Tcy
        if (tk & (s_reg.instruction_cycle_time == 3'(adcseq_pkg::TCY_CYCLES - 1)))
        begin
          s_next.st = adcseq_pkg::ADCSEQ_CONV;
          s_next.cnt = 4'h0;
          s_next.sar = 10'h200;
        end
      end
      adcseq_pkg::ADCSEQ_CONV:
      begin
        // Channel and direction bits are not consulted here
        if (done_evt)
        begin
          // Set of the flag wins over a software clear
          {s_next.res_hi, s_next.res_lo} = pair;
          s_next.ctrl[adcseq_pkg::CTL_GO_BIT] = 1'b0;
          s_next.irqf = 1'b1;
          s_next.sar = final_code;
          s_next.st = adcseq_pkg::ADCSEQ_WAIT;
          s_next.cnt = 4'h0;
          s_next.restart = 1'b1;
        end
        else if (tk)
        begin
          // One decision per period while the count is below nine, msb first
          s_next.cnt = s_reg.cnt + 4'h1;
          if (s_reg.cnt < 4'h9)
          begin
            if (!s_reg.cmp_s2)
              s_next.sar[4'h9 - s_reg.cnt] = 1'b0;
            s_next.sar[4'h8 - s_reg.cnt] = 1'b1;
          end
        end
      end
      adcseq_pkg::ADCSEQ_WAIT:
      begin
        // Hold stays disconnected, keeps its charge
        if (tk)
          s_next.cnt = s_reg.cnt + 4'h1;
        if (tk & (s_reg.cnt == adcseq_pkg::POST_TADS - 4'h1))
          s_next.st = adcseq_pkg::ADCSEQ_IDLE;
      end
    endcase
    // Aborts: software clear, power off, sleep off the RC clock
    // Completion clears go itself and must not count as an abort
    if (busy & ~done_evt & (~s_next.ctrl[adcseq_pkg::CTL_GO_BIT]
        | ~s_next.ctrl[adcseq_pkg::CTL_ON_BIT]
        | (sleep_mode & ~is_rc)))
    begin
      abort_evt = 1'b1;
      s_next.ctrl[adcseq_pkg::CTL_GO_BIT] = 1'b0;
      s_next.st = adcseq_pkg::ADCSEQ_WAIT;
      s_next.cnt = 4'h0;
      s_next.restart = 1'b1;
    end
    // Outputs, registered from the next state, so in step with the state they show
    s_next.hold = (s_next.st == adcseq_pkg::ADCSEQ_IDLE)
      & s_next.ctrl[adcseq_pkg::CTL_ON_BIT];
    s_next.active = s_next.ctrl[adcseq_pkg::CTL_ON_BIT]
      & ~(sleep_mode & ~is_rc);
    s_next.irq = s_next.irqf & s_next.irqe & s_next.global_irq_enable;
    s_next.wake = sleep_mode & s_next.irqf & s_next.irqe;
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset powers the converter off and drops any conversion
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.st <= adcseq_pkg::ADCSEQ_IDLE;
      s_reg.ctrl <= adcseq_pkg::CTL_RESET;
      s_reg.cfg <= adcseq_pkg::CFG_RESET;
      s_reg.amask <= adcseq_pkg::MASK_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  assign prdata = {24'h000000, s_reg.prdata};
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign dac_code = s_reg.sar;
  assign channel_sel = s_reg.ctrl[5:3];
  assign hold_connect = s_reg.hold;
  assign module_active = s_reg.active;
  assign conv_done_irq = s_reg.irq;
  assign wake_req = s_reg.wake;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DONE_CLEARS_GO: assert property (
    @(posedge ref_clk) disable iff (reset)
    done_evt |=> !s_reg.ctrl[adcseq_pkg::CTL_GO_BIT] && s_reg.irqf
      && s_reg.st == adcseq_pkg::ADCSEQ_WAIT)
    else $error("completion did not clear go or set flag");
  AST_JUSTIFY: assert property (
    @(posedge ref_clk) disable iff (reset)
    done_evt |=> {s_reg.res_hi, s_reg.res_lo}
      == ($past(s_reg.cfg[adcseq_pkg::CFG_JUSTIFY_BIT])
      ? {6'h00, $past(final_code)} : {$past(final_code), 6'h00}))
    else $error("result pair not justified as selected");
  AST_BIT1_ZERO: assert property (
    @(posedge ref_clk) disable iff (reset)
    !s_reg.ctrl[1])
    else $error("control bit one not zero");
  AST_PORT_ZERO: assert property (
    @(posedge ref_clk) disable iff (reset)
    acc && !s_reg.pready && !pwrite && idx == adcseq_pkg::IDX_PORT
      |=> (s_reg.prdata & $past(s_reg.amask)) == 8'h00)
    else $error("analog pin read nonzero");
  AST_ABORT_KEEP: assert property (
    @(posedge ref_clk) disable iff (reset)
    abort_evt && !wr_en |=> $stable(s_reg.res_hi) && $stable(s_reg.res_lo))
    else $error("abort changed result pair");
  AST_WAIT_HOLD: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(s_reg.st == adcseq_pkg::ADCSEQ_WAIT) |=> !s_reg.hold [*2])
    else $error("hold connected during post wait");
  AST_RC_DELAY: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(s_reg.st == adcseq_pkg::ADCSEQ_DELAY)
      |-> (s_reg.st != adcseq_pkg::ADCSEQ_FIRST) [*4])
    else $error("RC start not delayed one instruction cycle");
  AST_FIRST_MIN: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(s_reg.st == adcseq_pkg::ADCSEQ_FIRST)
      |-> (s_reg.st != adcseq_pkg::ADCSEQ_CONV) [*4])
    else $error("first segment shorter than Tcy");
  AST_SLEEP_ABORT: assert property (
    @(posedge ref_clk) disable iff (reset)
    busy && sleep_mode && !is_rc |=> s_reg.st == adcseq_pkg::ADCSEQ_WAIT
      ##1 !s_reg.active)
    else $error("sleep did not abort non-RC conversion");
  AST_WAKE: assert property (
    @(posedge ref_clk) disable iff (reset)
    done_evt && sleep_mode && s_reg.irqe ##1 sleep_mode |-> s_reg.wake)
    else $error("no wake on completion in sleep");
endmodule : adcseq_top

// ==== adcseq_pkg.sv ====
// Constants and types shared by the conversion sequencer files
package adcseq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40; // Oscillator period at 25 MHz
  localparam int TCY_NS = 160; // Instruction cycle, four osc periods
  localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_TAD_NS = 4000; // Typical RC conversion period
  localparam int RC_TAD_CYCLES = RC_TAD_NS / CLK_PERIOD_NS;
  localparam int DIV2_CYCLES = 2;
  localparam int DIV8_CYCLES = 8;
  localparam int DIV32_CYCLES = 32;
  localparam logic [3:0] LAST_CONV_TICK = 4'ha; // 11 periods after first
  localparam logic [3:0] POST_TADS = 4'h2; // Wait after end or abort
  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PORT = 8'h05;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1e;
  localparam logic [7:0] IDX_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h9e;
  localparam logic [7:0] IDX_PORT_CONFIG = 8'h9f;
  localparam logic [7:0] IDX_IRQ = 8'hc0;
  localparam logic [7:0] IDX_ANALOG_MASK = 8'hc1;
  // ----------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------
  localparam int CTL_CLK_LSB = 6;
  localparam int CTL_CHAN_LSB = 3;
  localparam int CTL_GO_BIT = 2;
  localparam int CTL_ON_BIT = 0;
  localparam int CFG_JUSTIFY_BIT = 7;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_GIE_BIT = 2;
  localparam logic [7:0] CTL_WMASK = 8'hfd;
  localparam logic [7:0] CFG_WMASK = 8'h8f;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  // Conversion clock choices
  typedef enum logic [1:0] {
    ADCSEQ_CLK_DIV2 = 2'h0,
    ADCSEQ_CLK_DIV8 = 2'h1,
    ADCSEQ_CLK_DIV32 = 2'h2,
    ADCSEQ_CLK_RC = 2'h3
  } adcseq_clksel_t;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ADCSEQ_IDLE = 5'h01,
    ADCSEQ_DELAY = 5'h02,
    ADCSEQ_FIRST = 5'h04,
    ADCSEQ_CONV = 5'h08,
    ADCSEQ_WAIT = 5'h10
  } adcseq_state_t;
endpackage : adcseq_pkg

// ==== adcseq_tad_gen.sv ====
// Per-bit conversion period tick generator
`timescale 1ns/1ps
module adcseq_tad_gen #(
  parameter int RC_CYCLES = adcseq_pkg::RC_TAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic restart,
  input wire adcseq_pkg::adcseq_clksel_t sel,
  output logic tick
);
  // ----------------------------------------------------------------
  // Checks and state
  // ----------------------------------------------------------------
  if (RC_CYCLES < 2 || RC_CYCLES > 128)
  begin : g_bad_rc
    $error("RC_CYCLES must lie in 2..128");
  end
  typedef struct packed {
    logic [6:0] cnt; // Cycles into current period
    logic tick; // One-cycle period pulse
  } adcseq_tg_t;
  adcseq_tg_t s_reg;
  adcseq_tg_t s_next;
  logic [6:0] last; // Final count of the period
  // ----------------------------------------------------------------
  // Period selection and counting
  // ----------------------------------------------------------------
  // Slower rates are enables, the whole block stays on one clock
  always_comb
  begin
    unique case (sel)
      adcseq_pkg::ADCSEQ_CLK_DIV2: last = 7'(adcseq_pkg::DIV2_CYCLES - 1);
      adcseq_pkg::ADCSEQ_CLK_DIV8: last = 7'(adcseq_pkg::DIV8_CYCLES - 1);
      adcseq_pkg::ADCSEQ_CLK_DIV32: last = 7'(adcseq_pkg::DIV32_CYCLES - 1);
      adcseq_pkg::ADCSEQ_CLK_RC: last = 7'(RC_CYCLES - 1);
    endcase
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (restart)
    begin
      // Restart aligns the first period to the start event; starting at
      // two pays for the restart and tick registers, so the first tick
      // is seen one full period after the start, or three cycles after it for the two-cycle period
      s_next.cnt = 7'h02;
    end
    else if (s_reg.cnt >= last)
    begin
      s_next.cnt = 7'h00;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 7'h01;
    end
  end
  // State register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign tick = s_reg.tick;
endmodule : adcseq_tad_gen

// ==== adcseq_analog_src.sv ====
// Behavioural analog source and sample-and-hold facing the sequencer
`timescale 1ns/1ps
module adcseq_analog_src (
  input wire logic [9:0] level,
  input wire logic [7:0] pin_level,
  input wire logic [9:0] dac_code,
  input wire logic hold_connect,
  output logic comparator_in,
  output logic [7:0] port_pins
);
  // ----------
  // Hold capacitor
  // ----------
  logic [9:0] held = 10'h000; // Charge left on the hold capacitor
  // Tracks the input only while connected; never discharged
  always @(hold_connect or level)
    if (hold_connect === 1'b1)
      held = level;
  // Comparator weighs the held charge against the trial code
  assign comparator_in = (held >= dac_code);
  // Digital pin levels, whatever the conversion does
  assign port_pins = pin_level;
endmodule : adcseq_analog_src

// ==== tb.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CTL = adcseq_pkg::IDX_CONTROL;
  localparam logic [7:0] CFG = adcseq_pkg::IDX_PORT_CONFIG;
  localparam logic [7:0] RHI = adcseq_pkg::IDX_RESULT_HIGH;
  localparam logic [7:0] RLO = adcseq_pkg::IDX_RESULT_LOW;
  localparam logic [7:0] IRQ = adcseq_pkg::IDX_IRQ;
  // Only the RC period meets the minimum period at this clock; the
  // divided periods exercise the selector against an ideal source
  localparam int RC = adcseq_pkg::RC_TAD_CYCLES;
  localparam int TD [4] = '{adcseq_pkg::DIV2_CYCLES,
    adcseq_pkg::DIV8_CYCLES, adcseq_pkg::DIV32_CYCLES, RC};
  // Two cycles per period is shorter than the comparator synchroniser,
  // so that choice gets full scale, which every decision keeps
  localparam logic [9:0] LV [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h155};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic sleep_mode = 1'b0;
  logic [9:0] level = 10'h000; // Analog level on the channel
  logic [7:0] pins = 8'hff; // Digital pin levels
  logic [31:0] prdata;
  logic [7:0] port_pins;
  logic [9:0] dac_code;
  logic [2:0] channel_sel;
  logic pready, pslverr, comparator_in, hold_connect;
  logic module_active, conv_done_irq, wake_req;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0; // Free-running cycle count
  logic [7:0] r;
  logic e;
  int n;
  adcseq_top #(.RC_CYCLES(RC)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins),
    .comparator_in(comparator_in), .sleep_mode(sleep_mode),
    .dac_code(dac_code), .channel_sel(channel_sel),
    .hold_connect(hold_connect), .module_active(module_active),
    .conv_done_irq(conv_done_irq), .wake_req(wake_req));
  adcseq_analog_src src_u (.level(level), .pin_level(pins),
    .dac_code(dac_code), .hold_connect(hold_connect),
    .comparator_in(comparator_in), .port_pins(port_pins));
  // ----------
  // Clock and helpers
  // ----------
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic timeout();
    num_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    end_of_test();
  endtask : timeout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; pready is sampled before the edge's updates land
  task automatic apb(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd, output logic [7:0] rd, output logic err);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16) timeout();
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    logic y;
    apb(1'b1, idx, d, x, y);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    logic y;
    apb(1'b0, idx, 8'h00, x, y);
    chk({24'h000000, x}, {24'h000000, exp});
  endtask : rdc
  // Full conversion with one clock choice, polled until go clears
  task automatic conv(input logic [1:0] sel, input logic just,
    input logic [9:0] lvl, input int tad);
    logic [15:0] ex;
    logic ok;
    int t0;
    int k;
    ex = just ? {6'h00, lvl} : {lvl, 6'h00};
    level <= lvl;
    wr(CFG, {just, 7'h00});
    wr(CTL, {sel, 6'h11});
    repeat (4 * tad + 8) @(posedge ref_clk);
    wr(IRQ, 8'h06);
    wr(CTL, {sel, 6'h15});
    t0 = cyc;
    sleep_mode <= (sel == 2'h3);
    k = 0;
    do
    begin
      apb(1'b0, CTL, 8'h00, r, e);
      k++;
    end
    while (r[2] !== 1'b0 && k < 400);
    if (k >= 400) timeout();
    ok = (cyc - t0 >= 11 * tad + adcseq_pkg::TCY_CYCLES);
    ok = ok && (cyc - t0 <= 14 * tad + 24);
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, conv_done_irq}, 32'h1);
    chk({31'h0, wake_req}, {31'h0, sleep_mode});
    sleep_mode <= 1'b0;
    rdc(RHI, ex[15:8]);
    rdc(RLO, ex[7:0]);
    rdc(IRQ, 8'h07);
  endtask : conv
  // ----------
  // Main sequence
  // ----------
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(CTL, 8'h00);
    rdc(CFG, 8'h00);
    rdc(adcseq_pkg::IDX_PORT, 8'h00);
    wr(CTL, 8'h3f); // Go while off must be dropped
    rdc(CTL, 8'h39);
    chk({29'h0, channel_sel}, 32'h7);
    apb(1'b0, 8'h40, 8'h00, r, e);
    chk({23'h0, e, r}, 32'h100); // Unmapped place
    wr(adcseq_pkg::IDX_ANALOG_MASK, 8'h0f);
    rdc(adcseq_pkg::IDX_PORT, 8'hf0);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
      conv(2'(i), 1'(i), LV[i], TD[i]);
    $display("test conversions done");
    wr(CTL, 8'h85);
    level <= 10'h0aa;
    repeat (40) @(posedge ref_clk);
    wr(CTL, 8'h81); // Clear go as the post wait ends, before the pending conversion starts
    rdc(CTL, 8'h81);
    rdc(RHI, 8'h01);
    rdc(RLO, 8'h55);
    n = 0;
    while (hold_connect !== 1'b1 && n < 104)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, hold_connect}, 32'h1);
    wr(CTL, 8'h45);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, module_active}, 32'h0);
    sleep_mode <= 1'b0;
    rdc(CTL, 8'h41);
    $display("test abort done");
    wr(CTL, 8'h00);
    wr(RHI, 8'h5a);
    wr(RLO, 8'hc3);
    rdc(RHI, 8'h5a);
    rdc(RLO, 8'hc3);
    wr(CTL, 8'h81);
    wr(CTL, 8'h85);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    chk({31'h0, module_active}, 32'h0);
    rdc(CTL, 8'h00);
    $display("test storage and reset done");
    end_of_test();
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    timeout();
  end
endmodule : tb
